/* File: hdl/seq_pkg.sv */
// Purpose: Shared constants and types for the measurement sequencer
// Assumes: 200 MHz system clock, one clock domain
// Notes:   Time figures are kept in their own units; cycles derive from them
`default_nettype none

package seq_pkg;

  // Clock period in picoseconds (200 MHz)
  localparam int CLK_PERIOD_PS = 5000;

  // Standby wake-up time, least time, rounded up to whole cycles
  localparam int STANDBY_WAKE_NS = 4000;
  localparam int WAKE_CYCLES =
    (STANDBY_WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  // Power-up startup time (1.2 ms typical), rounded down
  localparam int POWER_UP_START_US = 1200;
  localparam int POWER_UP_CYCLES =
    (POWER_UP_START_US * 1000000) / CLK_PERIOD_PS;

  // Clock counts per internally timed conversion window
  localparam int WINDOW_CLOCKS = 1024;
  // Cycles per pause step (one pause unit)
  localparam int PAUSE_TICK_CYCLES = 200;

  localparam int RESULT_W = 24;
  localparam int NUM_CH = 3;

  // Operational state field codes
  localparam logic [2:0] CONFIG_STATE = 3'h2;
  localparam logic [2:0] MEAS_STATE = 3'h3;
  // Operation state register layout
  localparam int OPSTATE_SS_BIT = 7;
  localparam int OPSTATE_PD_BIT = 6;
  localparam logic [2:0] OPSTATE_RSVD = 3'h0;

  typedef enum logic [1:0] {
    single_shot_mode = 2'h0,
    free_running_mode = 2'h1,
    trigger_start_mode = 2'h2,
    trigger_window_mode = 2'h3
  } mode_t;

  typedef enum logic [7:0] {
    st_idle = 8'h01,
    st_pdown = 8'h02,
    st_stby = 8'h04,
    st_startup = 8'h08,
    st_wake = 8'h10,
    st_conv = 8'h20,
    st_pause = 8'h40,
    st_spare = 8'h80
  } seq_state_t;

  typedef struct packed {
    mode_t mode;
    logic power_down_bit;
    logic standby_enable;
    logic window_timing_enable;
    logic [2:0] operational_state_field;
    logic [7:0] pause_interval;
    logic [7:0] window_pulse_count;
  } cfg_t;

  typedef struct packed {
    logic in_power_down;
    logic in_standby;
    logic ready;
    logic result_valid;
  } status_t;

endpackage : seq_pkg

`default_nettype wire

/* File: hdl/chan_accum.sv */
// Purpose: Pulse-density accumulator for one converter channel
// Assumes: pulse input already synchronised to clk_sys
// Notes:   Saturates instead of wrapping, so an overrange reads full scale
`default_nettype none

module chan_accum #(
  parameter int W = 24
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clear,
  input wire logic count_en,
  input wire logic pulse,
  output logic [W-1:0] count
);

  typedef struct packed {
    logic [W-1:0] count;
  } acc_t;

  acc_t r;
  acc_t next_r;

  // Clear wins over counting so each window starts from zero
  always_comb begin
    next_r = r;
    if (clear) begin
      next_r.count = '0;
    end else if (count_en && pulse && r.count != {W{1'b1}}) begin
      next_r.count = r.count + {{(W-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign count = r.count;

endmodule : chan_accum

`default_nettype wire

/* File: hdl/measurement_sequencer.sv */
// Purpose: Conversion sequencing and energy-saving state control
// Assumes: cfg and start/stop strobes come from logic on clk_sys;
//          trigger pin and converter pulse streams are asynchronous
// Notes:   Function
`default_nettype none

module measurement_sequencer
  import seq_pkg::*;
#(
  parameter int PU_CYCLES = POWER_UP_CYCLES,
  parameter int CONV_CLOCKS = WINDOW_CLOCKS,
  parameter int PAUSE_TICK = PAUSE_TICK_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire cfg_t cfg,
  input wire logic start_req,
  input wire logic stop_req,
  input wire logic external_trigger_pin,
  input wire logic [NUM_CH-1:0] pdm_in,
  output logic start_stop,
  output logic [7:0] operation_state_reg,
  output status_t status,
  output logic [NUM_CH-1:0][RESULT_W-1:0] channel_result,
  output logic [RESULT_W-1:0] measured_window_clocks
);

  typedef struct packed {
    seq_state_t st;
    logic start_stop;
    logic go;
    logic [RESULT_W-1:0] cnt;
    logic [RESULT_W-1:0] win;
    logic [7:0] edges;
    logic [7:0] pause;
    logic [15:0] div;
    logic [2:0] trig;
    logic [1:0][NUM_CH-1:0] pdm_sync;
    status_t stat;
    logic [NUM_CH-1:0][RESULT_W-1:0] result;
    logic [RESULT_W-1:0] meas_clocks;
    logic [7:0] opstate;
  } seq_t;

  seq_t r;
  seq_t next_r;
  logic [NUM_CH-1:0][RESULT_W-1:0] acc_count;
  logic acc_clear;
  logic acc_en;

  // Helper terms
  logic run;
  logic trig_fall;
  logic tick;
  logic start_ok;
  logic internal_timed;
  logic active;
  logic [7:0] edge_limit;
  seq_state_t rest;

  always_comb begin
    run = (cfg.operational_state_field == MEAS_STATE) && r.start_stop;
    trig_fall = r.trig[2] && !r.trig[1];
    tick = (r.div == 16'(PAUSE_TICK - 1));
    internal_timed = (cfg.mode != trigger_window_mode);
    // Trigger modes need a falling edge, others start on the bit alone
    start_ok = (cfg.mode == single_shot_mode) ||
               (cfg.mode == free_running_mode) || trig_fall;
    edge_limit = (cfg.window_pulse_count == 8'h00) ? 8'h01 :
                 cfg.window_pulse_count;
    rest = cfg.power_down_bit ? st_pdown :
           (cfg.standby_enable ? st_stby : st_idle);
    active = (r.st == st_wake) || (r.st == st_conv) ||
             (r.st == st_pause) || (r.st == st_startup && r.go);
  end

  // Sequencer next state
  always_comb begin
    next_r = r;
    next_r.stat.result_valid = 1'b0;
    // Pin first stage feeds only the second stage
    next_r.trig = {r.trig[1], r.trig[0], external_trigger_pin};
    next_r.pdm_sync = {r.pdm_sync[0], pdm_in};
    next_r.div = tick ? 16'h0000 : r.div + 16'h0001;
    if (stop_req) begin
      next_r.start_stop = 1'b0;
    end
    if (start_req) begin
      next_r.start_stop = 1'b1;
    end

    if (!run && active) begin
      // Abort: nothing is latched; startup itself still completes
      if (r.st == st_startup) begin
        next_r.go = 1'b0;
      end else begin
        next_r.st = rest;
      end
    end else begin
      unique case (r.st)
        st_idle, st_stby: begin
          if (run && start_ok) begin
            // Standby exit always pays the wake-up time
            next_r.st = (r.st == st_stby) ? st_wake : st_conv;
            next_r.cnt = '0;
          end else if (!(run && cfg.mode == single_shot_mode)) begin
            next_r.st = rest;
            next_r.go = 1'b0;
            next_r.cnt = '0;
          end
        end
        st_pdown: begin
          if (run && start_ok) begin
            next_r.st = st_startup;
            next_r.go = 1'b1;
            next_r.cnt = '0;
          end else if (!cfg.power_down_bit) begin
            next_r.st = st_startup;
            next_r.go = 1'b0;
            next_r.cnt = '0;
          end
        end
        st_startup: begin
          next_r.cnt = r.cnt + 24'h000001;
          if (r.cnt == 24'(PU_CYCLES - 1)) begin
            next_r.cnt = '0;
            next_r.go = 1'b0;
            if (r.go) begin
              // With standby enabled, wake-up follows startup; otherwise conversion starts directly
              next_r.st = cfg.standby_enable ? st_wake : st_conv;
            end else begin
              next_r.st = cfg.standby_enable ? st_stby : st_idle;
            end
          end
        end
        st_wake: begin
          next_r.cnt = r.cnt + 24'h000001;
          if (r.cnt == 24'(WAKE_CYCLES - 1)) begin
            next_r.st = st_conv;
          end
        end
        st_conv: begin
          next_r.cnt = r.cnt + 24'h000001;
          next_r.win = r.win + 24'h000001;
          if (trig_fall) begin
            next_r.edges = r.edges + 8'h01;
          end
          if ((internal_timed &&
               r.cnt == 24'(CONV_CLOCKS - 1)) ||
              (!internal_timed && trig_fall &&
               r.edges + 8'h01 >= edge_limit)) begin
            next_r.result = acc_count;
            if (cfg.window_timing_enable) begin
              next_r.meas_clocks = r.win + 24'h000001;
            end
            next_r.stat.result_valid = 1'b1;
            if (cfg.mode == single_shot_mode) begin
              // Set by software in the same cycle still wins
              next_r.start_stop = start_req;
              next_r.st = rest;
            end else begin
              next_r.st = st_pause;
              next_r.pause = cfg.pause_interval;
            end
          end
        end
        st_pause: begin
          // Edges are not looked at here, so they are dropped
          if (tick) begin
            if (r.pause == 8'h00) begin
              if (cfg.mode == free_running_mode) begin
                next_r.st = cfg.standby_enable ? st_wake : st_conv;
                next_r.cnt = '0;
              end else begin
                next_r.st = rest;
              end
            end else begin
              next_r.pause = r.pause - 8'h01;
            end
          end
        end
        default: begin
          next_r.st = st_pdown;
        end
      endcase
    end

    // Fresh window: counters restart on entry
    if (next_r.st == st_conv && r.st != st_conv) begin
      next_r.cnt = '0;
      next_r.win = '0;
      next_r.edges = 8'h00;
    end
    next_r.stat.ready = (next_r.st == st_conv);
    next_r.stat.in_power_down = (next_r.st == st_pdown);
    next_r.stat.in_standby = (next_r.st == st_stby) ||
      (next_r.st == st_pause && cfg.standby_enable);
    next_r.opstate = {next_r.start_stop, cfg.power_down_bit, OPSTATE_RSVD,
                      cfg.operational_state_field};
  end

  // Power-on state is power down with conversion stopped
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      r <= '0;
      r.st <= st_pdown;
      r.stat.in_power_down <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  always_comb begin
    acc_clear = (r.st != st_conv);
    acc_en = (r.st == st_conv);
  end

  // One accumulator per channel
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    chan_accum #(
      .W(RESULT_W)
    ) u_acc (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .clear(acc_clear),
      .count_en(acc_en),
      .pulse(r.pdm_sync[1][i]),
      .count(acc_count[i])
    );
  end

  assign start_stop = r.start_stop;
  assign operation_state_reg = r.opstate;
  assign status = r.stat;
  assign channel_result = r.result;
  assign measured_window_clocks = r.meas_clocks;

  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  a_single_clears_ss: assert property (
    $past(r.st == st_conv) && r.stat.result_valid &&
    $past(cfg.mode == single_shot_mode) && !$past(start_req)
    |-> !r.start_stop)
    else $error("start/stop still set after single-shot end");

  a_single_to_pdown: assert property (
    $past(r.st == st_conv) && r.stat.result_valid &&
    $past(cfg.mode == single_shot_mode) && $past(cfg.power_down_bit)
    |-> r.stat.in_power_down)
    else $error("single-shot end did not enter power down");

  a_single_to_idle: assert property (
    r.stat.result_valid && $past(cfg.mode == single_shot_mode) &&
    !$past(cfg.power_down_bit) && !$past(cfg.standby_enable)
    |-> r.st == st_idle)
    else $error("single-shot end did not return to idle");

  a_pause_after_latch: assert property (
    r.stat.result_valid && $past(cfg.mode) != single_shot_mode
    |-> r.st == st_pause && r.pause == $past(cfg.pause_interval))
    else $error("pause did not start at result latch");

  a_abort_stop: assert property (
    r.st == st_conv && !run |=> r.st != st_conv && !r.stat.result_valid)
    else $error("conversion not aborted or result kept");

  a_pause_no_conv: assert property (
    r.st == st_pause && cfg.mode != free_running_mode
    |=> r.st != st_conv && r.st != st_wake)
    else $error("trigger accepted during pause");

  a_standby_pause: assert property (
    r.st == st_pause && $past(cfg.standby_enable) |-> r.stat.in_standby)
    else $error("no standby during pause");

  a_wake_holds: assert property (
    r.st == st_wake && r.cnt != 24'(WAKE_CYCLES - 1) && run
    |=> r.st == st_wake && r.cnt == $past(r.cnt) + 24'h000001)
    else $error("wake-up ended early");

  a_ready_window: assert property (
    $rose(r.stat.ready) |-> r.cnt == '0 && r.win == '0 ##1 acc_en)
    else $error("ready not aligned to conversion start");

  a_fixed_window: assert property (
    $fell(r.stat.ready) && $past(internal_timed) && $past(run)
    |-> $past(r.cnt) == 24'(CONV_CLOCKS - 1))
    else $error("internal window length wrong");

endmodule : measurement_sequencer

`default_nettype wire

/* File: verification/trig_source.sv */
// Purpose: Far-side model: trigger source and converter pulse streams
// Assumes: Caller picks edge spacing; pin idles high through a pull-up
// Notes:   Changes only on falling clock edges, well away from sampling
`default_nettype none

module trig_source
  import seq_pkg::*;
(
  input wire logic clk_sys,
  output logic external_trigger_pin,
  output logic [NUM_CH-1:0] pdm_in
);
  timeunit 1ns;
  timeprecision 100ps;

  // Released pin floats to its pull-up level
  initial begin
    external_trigger_pin = 1'b1;
  end

  // First channel always pulses, last never: both count limits are seen
  assign pdm_in = {{(NUM_CH-1){1'b0}}, 1'b1};

  // Falling edges at a fixed spacing; a tight spacing is a choice
  task automatic edges(input int cnt, input int gap);
    repeat (cnt) begin
      @(negedge clk_sys);
      external_trigger_pin = 1'b0;
      repeat (gap / 2) @(negedge clk_sys);
      external_trigger_pin = 1'b1;
      repeat (gap - gap / 2 - 1) @(negedge clk_sys);
    end
  endtask : edges

endmodule : trig_source

`default_nettype wire

/* File: verification/measurement_sequencer_bench.sv */
// Purpose: Self-checking bench for the measurement sequencer
// Assumes: Short startup, window and pause counts for run time
// Notes:   Each scenario starts from a fresh reset into power down
`default_nettype none

module measurement_sequencer_bench
  import seq_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int PU = 20;
  localparam int CONV = 16;
  localparam int TICK = 4;

  logic clk_sys;
  logic rstn;
  cfg_t cfg;
  logic start_req;
  logic stop_req;
  logic external_trigger_pin;
  logic [NUM_CH-1:0] pdm_in;
  logic start_stop;
  logic [7:0] operation_state_reg;
  status_t status;
  logic [NUM_CH-1:0][RESULT_W-1:0] channel_result;
  logic [RESULT_W-1:0] measured_window_clocks;
  int total_checks = 0;
  int miscompares = 0;

  measurement_sequencer #(
    .PU_CYCLES(PU),
    .CONV_CLOCKS(CONV),
    .PAUSE_TICK(TICK)
  ) i_dut (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .cfg(cfg),
    .start_req(start_req),
    .stop_req(stop_req),
    .external_trigger_pin(external_trigger_pin),
    .pdm_in(pdm_in),
    .start_stop(start_stop),
    .operation_state_reg(operation_state_reg),
    .status(status),
    .channel_result(channel_result),
    .measured_window_clocks(measured_window_clocks)
  );

  trig_source i_src (
    .clk_sys(clk_sys),
    .external_trigger_pin(external_trigger_pin),
    .pdm_in(pdm_in)
  );

  // 200 MHz system clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  task automatic results();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : results

  task automatic chk(input string nm, input logic [23:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask : chk

  // Unknown inputs give an unknown result, which never matches 1
  function automatic logic inr(input logic [23:0] v, input int lo, hi);
    return (v >= 24'(lo)) && (v <= 24'(hi));
  endfunction : inr

  // Nonzero pause always, so no traffic overlaps a window
  function automatic cfg_t mk(mode_t m, logic pwr, stb, logic [2:0] opst);
    mk = '{mode: m, power_down_bit: pwr, standby_enable: stb,
      window_timing_enable: 1'b1, operational_state_field: opst,
      pause_interval: 8'h02, window_pulse_count: 8'h03};
  endfunction : mk

  task automatic rst();
    rstn = 1'b0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
  endtask : rst

  // One-cycle strobe, released before the next sampling edge
  task automatic go(input logic stp);
    @(negedge clk_sys);
    if (stp) stop_req = 1'b1;
    else start_req = 1'b1;
    @(negedge clk_sys);
    stop_req = 1'b0;
    start_req = 1'b0;
  endtask : go

  // Bounded wait for ready to reach a level; a timeout ends the run
  task automatic wr(input logic lvl, input int lim, output int n);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (status.ready !== lvl && n < lim);
    if (status.ready !== lvl) begin
      miscompares++;
      $display("wrong value ready wait expected %0h seen timeout", lvl);
      results();
    end
  endtask : wr

  task automatic cnt(input int cyc, output int h);
    h = 0;
    repeat (cyc) begin
      @(negedge clk_sys);
      if (status.ready === 1'b1) h++;
    end
  endtask : cnt

  // Main sequence: single shot, free running, both trigger modes
  initial begin
    int n;
    int hits;
    cfg = mk(single_shot_mode, 1'b1, 1'b1, MEAS_STATE);
    start_req = 1'b0;
    stop_req = 1'b0;
    rst();
    go(1'b0);
    wr(1'b1, 2000, n);
    chk("wake", inr(24'(n), PU + WAKE_CYCLES - 2,
        PU + WAKE_CYCLES + 8), 1);
    wr(1'b0, 100, n);
    chk("window", 24'(n), CONV);
    chk("valid", status.result_valid, 1'b1);
    chk("ch0", inr(channel_result[0], CONV - 1, CONV), 1'b1);
    chk("chn", channel_result[NUM_CH-1], 24'h0);
    chk("ch1", channel_result[1], 24'h0);
    @(negedge clk_sys);
    chk("opstate", operation_state_reg, 8'h43);
    chk("pdn", status.in_power_down, 1'b1);
    // Single shot from idle, without and with standby
    for (int s = 0; s < 2; s++) begin
      cfg = mk(single_shot_mode, 1'b0, s[0], MEAS_STATE);
      rst();
      repeat (40) @(negedge clk_sys);
      go(1'b0);
      wr(1'b1, 1000, n);
      wr(1'b0, 100, n);
      repeat (2) @(negedge clk_sys);
      chk("stby", status.in_standby, s[0]);
      chk("pdn", status.in_power_down, 1'b0);
      chk("ss", start_stop, 1'b0);
    end
    // Free running with standby in the pause, then abort mid-window
    cfg = mk(free_running_mode, 1'b0, 1'b1, MEAS_STATE);
    rst();
    repeat (40) @(negedge clk_sys);
    go(1'b0);
    wr(1'b1, 1000, n);
    wr(1'b0, 100, n);
    @(negedge clk_sys);
    chk("pause stby", status.in_standby, 1'b1);
    wr(1'b1, 1000, n);
    chk("restart", inr(24'(n), 3 * TICK + WAKE_CYCLES - 6,
        4 * TICK + WAKE_CYCLES + 4), 1);
    repeat (4) @(negedge clk_sys);
    go(1'b1);
    wr(1'b0, 10, n);
    chk("abort", status.result_valid, 1'b0);
    cnt(900, hits);
    chk("stopped", 24'(hits), 24'h0);
    // Trigger start from power down; the later edges all fall in wake-up
    cfg = mk(trigger_start_mode, 1'b1, 1'b1, MEAS_STATE);
    rst();
    go(1'b0);
    cnt(30, hits);
    chk("await edge", 24'(hits), 24'h0);
    fork
      i_src.edges(6, 120);
    join_none
    wr(1'b1, 2000, n);
    chk("trig start", inr(24'(n), PU + WAKE_CYCLES,
        PU + WAKE_CYCLES + 12), 1);
    // Two edges inside the window, the third inside the pause
    fork
      i_src.edges(3, 10);
    join_none
    wr(1'b0, 100, n);
    @(negedge clk_sys);
    chk("stby", status.in_standby, 1'b1);
    // Long enough to see a restart through startup and wake-up
    cnt(1000, hits);
    chk("ignored", 24'(hits), 24'h0);
    // Trigger window: pulses in configuration state do nothing
    cfg = mk(trigger_window_mode, 1'b0, 1'b0, CONFIG_STATE);
    rst();
    repeat (40) @(negedge clk_sys);
    go(1'b0);
    fork
      i_src.edges(4, 20);
      cnt(100, hits);
    join
    chk("cfg ignore", 24'(hits), 24'h0);
    cfg.operational_state_field = MEAS_STATE;
    repeat (10) @(negedge clk_sys);
    fork
      i_src.edges(4, 40);
    join_none
    wr(1'b1, 100, n);
    wr(1'b0, 300, n);
    chk("edges", inr(24'(n), 119, 121), 1'b1);
    chk("clocks", inr(measured_window_clocks, 119, 122), 1'b1);
    results();
  end

endmodule : measurement_sequencer_bench

`default_nettype wire
